// ---- include/vic_pkg.sv ----
package vic_pkg;

    // ==========================================================
    // Source numbering, in fixed arbitration order.
    localparam int NUM_SRC = 18;
    localparam int NUM_EXT = 4;
    localparam int NUM_PER = 8;
    localparam int SRC_NMI = 4;
    localparam int SRC_EXT = 6;
    localparam int SRC_PER = 10;
    localparam int NUM_PINS = 5;

    // ==========================================================
    // Register map: index times four is the byte address.
    localparam int ADR_W = 18;
    localparam logic [15:0] PERIPH_PRIO_INDEX = 16'hFFFE;
    localparam logic [15:0] CORE_PRIO_INDEX = 16'hFFFF;
    localparam logic [15:0] PENDING_INDEX = 16'hFFFD;
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    localparam logic [15:0] CORE_PRIO_USED = 16'h0FFF;

    // ==========================================================
    // Field layout and level codes.
    localparam int EXT_FIELD_W = 3;
    localparam int TRIG_POS = 2;
    localparam int PER_FIELD_W = 2;
    localparam logic [1:0] LEVEL_OFF = 2'h0;
    localparam logic [1:0] LEVEL_STEP = 2'h1;
    localparam logic [1:0] LEVEL_TOP = 2'h3;

    // ==========================================================
    // Vector offsets within the 256-word table, two words each.
    localparam logic [7:0] VEC_OFFSET [NUM_SRC] = '{
        8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'hFE,
        8'h10, 8'h12, 8'h14, 8'h16,
        8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h30, 8'h32
    };
    localparam logic [15:0] SECOND_WORD = 16'h0001;

    // ==========================================================
    // Vector fetch sequencer and inserted-word tracking.
    typedef enum logic [1:0] {ST_IDLE, ST_WORD1, ST_WORD2} fetch_state_type;
    localparam logic [1:0] WORDS_DONE = 2'h2;
    localparam logic [1:0] WORDS_ONE = 2'h1;

endpackage : vic_pkg

// ---- src/vectored_interrupt_controller.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Every source owns its own vector address.
// - Pin requests synchronised, one pending flag per source.
// - Drop requests below mask; pick highest level.
// - Freeze program counter, fetch two vector words.
// - Release counter after both words; rearbitrate.
// - No subroutine jump: fast, nothing stacked.
// - Any subroutine jump: stack status and counter.
// - Table of 256 words, two per source.
// - Core vectors at fixed offsets, level three.
// - External and peripheral vectors, maskable levels.
// - Four levels; level three never masked.
// - Internal requests cleared on service, own enables.
// - Non-maskable pin is edge triggered.
// - Edge mode pends on falling input.
// - Disabled external: ignored, edge latch held reset.
// - Undefined opcode raises level three exception.
// - Software trap raises level three exception.
// - Mask bits block levels below their value.
// - Two-bit field: off, or level zero to two.
// - Trigger select: zero level, one falling edge.
// - Two priority registers, cleared by either reset.
// - Fixed order breaks ties within a level.
// - Pending held until second vector fetch.
module vectored_interrupt_controller (
    // Clock and resets.
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic reset_instr_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [vic_pkg::ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Core and peripheral requests, one-cycle pulses.
    input wire logic stack_error_in,
    input wire logic illegal_opcode_exception_in,
    input wire logic debug_request_in,
    input wire logic trap_in,
    input wire logic periph_nmi_in,
    input wire logic [vic_pkg::NUM_PER-1:0] periph_req_in,
    // External request pins, active low.
    input wire logic nmi_n_in,
    input wire logic ext_request_a_n_in,
    input wire logic ext_request_b_n_in,
    input wire logic ext_request_c_n_in,
    input wire logic ext_request_d_n_in,
    // Status register mask and fetch pipeline.
    input wire logic mask_high_bit_in,
    input wire logic mask_low_bit_in,
    input wire logic [15:0] vector_base_in,
    input wire logic fetch_slot_in,
    input wire logic inserted_word_in,
    input wire logic inserted_is_jump_in,
    output logic freeze_pc_out,
    output logic vector_fetch_out,
    output logic [15:0] vector_addr_out,
    output logic [vic_pkg::NUM_EXT-1:0] ext_ack_out,
    output logic push_context_out,
    output logic fast_done_out
);

    // ==========================================================
    // Register bus.
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [15:0] core_prio_q, core_prio_d;
    logic [15:0] per_prio_q, per_prio_d;
    logic [vic_pkg::NUM_SRC-1:0] pend_q, pend_d;
    logic bus_req;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction : merge16

    assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;

    // Unmapped addresses still acknowledge, reading zero, so a stray access never hangs the bus.
    always_comb begin
        ack_d = bus_req;
        rdat_d = 32'h0000_0000;
        core_prio_d = core_prio_q;
        per_prio_d = per_prio_q;
        if (bus_req) begin
            if (wb_adr_in == {vic_pkg::CORE_PRIO_INDEX, 2'b00}) begin
                rdat_d = {16'h0000, core_prio_q};
                if (wb_we_in) begin
                    core_prio_d = merge16(core_prio_q, wb_dat_in, wb_sel_in) & vic_pkg::CORE_PRIO_USED;
                end
            end else if (wb_adr_in == {vic_pkg::PERIPH_PRIO_INDEX, 2'b00}) begin
                rdat_d = {16'h0000, per_prio_q};
                if (wb_we_in) begin
                    per_prio_d = merge16(per_prio_q, wb_dat_in, wb_sel_in);
                end
            end else if (wb_adr_in == {vic_pkg::PENDING_INDEX, 2'b00}) begin
                rdat_d = {14'h0000, pend_q};
            end
        end
        if (reset_instr_in) begin
            core_prio_d = vic_pkg::PRIO_RESET;
            per_prio_d = vic_pkg::PRIO_RESET;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            core_prio_q <= vic_pkg::PRIO_RESET;
            per_prio_q <= vic_pkg::PRIO_RESET;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            core_prio_q <= core_prio_d;
            per_prio_q <= per_prio_d;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // ==========================================================
    // Level and enable decode per source.
    logic [1:0] lvl [vic_pkg::NUM_SRC];
    logic [vic_pkg::NUM_SRC-1:0] en;
    logic [vic_pkg::NUM_SRC-1:0] cand;
    logic [vic_pkg::NUM_EXT-1:0] trig;
    logic [1:0] mask;

    assign mask = {mask_high_bit_in, mask_low_bit_in};

    genvar g;
    for (g = 0; g < vic_pkg::SRC_EXT; g++) begin : g_top
        assign en[g] = 1'b1;
        assign lvl[g] = vic_pkg::LEVEL_TOP;
    end
    for (g = 0; g < vic_pkg::NUM_EXT; g++) begin : g_ext
        logic [1:0] field;
        assign field = core_prio_q[g*vic_pkg::EXT_FIELD_W +: 2];
        assign en[vic_pkg::SRC_EXT+g] = field != vic_pkg::LEVEL_OFF;
        assign lvl[vic_pkg::SRC_EXT+g] = field - vic_pkg::LEVEL_STEP;
        assign trig[g] = core_prio_q[g*vic_pkg::EXT_FIELD_W+vic_pkg::TRIG_POS];
    end
    for (g = 0; g < vic_pkg::NUM_PER; g++) begin : g_per
        logic [1:0] field;
        assign field = per_prio_q[g*vic_pkg::PER_FIELD_W +: 2];
        assign en[vic_pkg::SRC_PER+g] = field != vic_pkg::LEVEL_OFF;
        assign lvl[vic_pkg::SRC_PER+g] = field - vic_pkg::LEVEL_STEP;
    end
    for (g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_cand
        // Level three passes any mask; lower levels need level >= mask.
        assign cand[g] = pend_q[g] && en[g] && (lvl[g] == vic_pkg::LEVEL_TOP || lvl[g] >= mask);
    end

    // ==========================================================
    // Arbitration: the lower index wins a tie, scanning downward.
    logic found;
    logic [4:0] win;
    logic [1:0] win_lvl;

    always_comb begin
        found = 1'b0;
        win = 5'h00;
        win_lvl = 2'h0;
        for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i] && (!found || lvl[i] >= win_lvl)) begin
                found = 1'b1;
                win = 5'(i);
                win_lvl = lvl[i];
            end
        end
    end

    // ==========================================================
    // Pin synchronisers and pending flags.
    logic [vic_pkg::NUM_PINS-1:0] pins, sync1_q, sync2_q, prev_q, prev_d;
    logic [vic_pkg::NUM_SRC-1:0] set_v, clr_v;

    assign pins = {nmi_n_in, ext_request_d_n_in, ext_request_c_n_in, ext_request_b_n_in, ext_request_a_n_in};

    always_comb begin
        prev_d = sync2_q;
        set_v = '0;
        set_v[0] = stack_error_in;
        set_v[1] = illegal_opcode_exception_in;
        set_v[2] = debug_request_in;
        set_v[3] = trap_in;
        set_v[vic_pkg::SRC_NMI] = prev_q[vic_pkg::NUM_EXT] && !sync2_q[vic_pkg::NUM_EXT];
        set_v[5] = periph_nmi_in;
        set_v[vic_pkg::SRC_PER +: vic_pkg::NUM_PER] = periph_req_in;
        for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
            set_v[vic_pkg::SRC_EXT+i] = trig[i] && prev_q[i] && !sync2_q[i];
        end
        // A new event in the clearing cycle survives: set wins.
        pend_d = set_v | (pend_q & ~clr_v);
        for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
            if (!en[vic_pkg::SRC_EXT+i]) begin
                // The edge detector keeps following the pin, so a pin already low at enable is no edge.
                pend_d[vic_pkg::SRC_EXT+i] = 1'b0;
            end else if (!trig[i]) begin
                pend_d[vic_pkg::SRC_EXT+i] = !sync2_q[i];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q <= '1;
            pend_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q <= prev_d;
            pend_q <= pend_d;
        end
    end

    // ==========================================================
    // Vector fetch sequencer and long/fast detection.
    vic_pkg::fetch_state_type state_q, state_d;
    logic [4:0] sel_q, sel_d;
    logic [15:0] addr_q, addr_d;
    logic fetch_q, fetch_d, freeze_q, freeze_d;
    logic [vic_pkg::NUM_EXT-1:0] ext_ack_q, ext_ack_d;
    logic [1:0] cnt_q, cnt_d;
    logic jump_q, jump_d, push_q, push_d, fast_q, fast_d;
    logic sel_is_ext, sel_level_mode;

    assign sel_is_ext = sel_q >= 5'(vic_pkg::SRC_EXT) && sel_q < 5'(vic_pkg::SRC_PER);
    assign sel_level_mode = sel_is_ext && !trig[2'(sel_q - 5'(vic_pkg::SRC_EXT))];

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        addr_d = addr_q;
        fetch_d = 1'b0;
        ext_ack_d = '0;
        clr_v = '0;
        push_d = 1'b0;
        fast_d = 1'b0;
        cnt_d = cnt_q;
        jump_d = jump_q;
        if (inserted_word_in && cnt_q != vic_pkg::WORDS_DONE) begin
            cnt_d = cnt_q + vic_pkg::WORDS_ONE;
            jump_d = jump_q || inserted_is_jump_in;
            if (cnt_q == vic_pkg::WORDS_ONE) begin
                push_d = jump_q || inserted_is_jump_in;
                fast_d = !(jump_q || inserted_is_jump_in);
            end
        end
        case (state_q)
            vic_pkg::ST_IDLE: begin
                if (fetch_slot_in && found) begin
                    state_d = vic_pkg::ST_WORD1;
                    sel_d = win;
                    addr_d = {vector_base_in[15:8], vic_pkg::VEC_OFFSET[win]};
                    fetch_d = 1'b1;
                    cnt_d = 2'h0;
                    jump_d = 1'b0;
                end
            end
            vic_pkg::ST_WORD1: begin
                if (fetch_slot_in) begin
                    state_d = vic_pkg::ST_WORD2;
                    addr_d = addr_q | vic_pkg::SECOND_WORD;
                    fetch_d = 1'b1;
                    // Level-mode external requests stay until the requester drops them.
                    clr_v[sel_q] = !sel_level_mode;
                    if (sel_is_ext) begin
                        ext_ack_d[2'(sel_q - 5'(vic_pkg::SRC_EXT))] = 1'b1;
                    end
                end
            end
            vic_pkg::ST_WORD2: begin
                state_d = vic_pkg::ST_IDLE;
            end
            default: begin
                state_d = vic_pkg::ST_IDLE;
            end
        endcase
        freeze_d = state_d != vic_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= vic_pkg::ST_IDLE;
            sel_q <= 5'h00;
            addr_q <= 16'h0000;
            fetch_q <= 1'b0;
            freeze_q <= 1'b0;
            ext_ack_q <= '0;
            cnt_q <= vic_pkg::WORDS_DONE;
            jump_q <= 1'b0;
            push_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            addr_q <= addr_d;
            fetch_q <= fetch_d;
            freeze_q <= freeze_d;
            ext_ack_q <= ext_ack_d;
            cnt_q <= cnt_d;
            jump_q <= jump_d;
            push_q <= push_d;
            fast_q <= fast_d;
        end
    end

    assign freeze_pc_out = freeze_q;
    assign vector_fetch_out = fetch_q;
    assign vector_addr_out = addr_q;
    assign ext_ack_out = ext_ack_q;
    assign push_context_out = push_q;
    assign fast_done_out = fast_q;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence word1_slot;
        state_q == vic_pkg::ST_WORD1 && fetch_slot_in;
    endsequence
    sequence word2_issue;
        fetch_q && state_q == vic_pkg::ST_WORD2 && addr_q[0];
    endsequence
    sequence released;
        !freeze_q && state_q == vic_pkg::ST_IDLE;
    endsequence

    chk_vector_pair: assert property (word1_slot |=> word2_issue ##1 released)
        else $error("second vector word or release missing");
    chk_first_vector: assert property ((state_q == vic_pkg::ST_IDLE && fetch_slot_in && found) |=>
        fetch_q && freeze_q && !addr_q[0] && addr_q[15:8] == $past(vector_base_in[15:8]))
        else $error("first vector fetch wrong");
    chk_mask_respected: assert property ((state_q == vic_pkg::ST_IDLE && fetch_slot_in && found) |->
        (win_lvl == vic_pkg::LEVEL_TOP || win_lvl >= mask))
        else $error("masked level selected");
    chk_pending_clear: assert property ((word1_slot and (!sel_level_mode && !set_v[sel_q])) |=>
        !pend_q[$past(sel_q)])
        else $error("serviced pending flag not cleared");
    chk_long_push: assert property ((inserted_word_in && cnt_q == vic_pkg::WORDS_ONE &&
        (jump_q || inserted_is_jump_in)) |=> push_context_out && !fast_done_out)
        else $error("long interrupt did not stack");
    chk_fast_path: assert property ((inserted_word_in && cnt_q == vic_pkg::WORDS_ONE &&
        !jump_q && !inserted_is_jump_in) |=> fast_done_out && !push_context_out)
        else $error("fast interrupt stacked state");
    chk_nmi_edge: assert property ((prev_q[vic_pkg::NUM_EXT] && !sync2_q[vic_pkg::NUM_EXT]) |=>
        pend_q[vic_pkg::SRC_NMI])
        else $error("pin edge not pending");
    chk_ext_disabled: assert property (!en[vic_pkg::SRC_EXT] |=>
        !pend_q[vic_pkg::SRC_EXT] && prev_q[0] == $past(sync2_q[0]))
        else $error("disabled external request pending");
    chk_ext_edge: assert property ((en[vic_pkg::SRC_EXT] && trig[0] && prev_q[0] && !sync2_q[0]) |=>
        pend_q[vic_pkg::SRC_EXT])
        else $error("falling edge not latched");
    chk_bus_ack: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
        else $error("bus acknowledge not single cycle");
    chk_reset_instr: assert property (reset_instr_in |=> core_prio_q == 16'h0000 && per_prio_q == 16'h0000)
        else $error("priority registers not cleared");

endmodule : vectored_interrupt_controller

`default_nettype wire

// ---- dv/fetch_pipeline_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ====================
// Fetch pipeline model
module fetch_pipeline_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Bench control.
    input wire logic enable_in,
    input wire logic [1:0] jump_mode_in,
    // Controller side.
    input wire logic vector_fetch_in,
    output logic fetch_slot_out,
    output logic inserted_word_out,
    output logic inserted_is_jump_out
);
    logic word_idx_q;

    always @(posedge clk_in) begin
        if (reset_in) begin
            fetch_slot_out <= 1'b0;
            inserted_word_out <= 1'b0;
            inserted_is_jump_out <= 1'b0;
            word_idx_q <= 1'b0;
        end else begin
            // Random stalls, so that both prompt and slow second-word slots occur.
            fetch_slot_out <= enable_in && ($urandom_range(3) != 0);
            inserted_word_out <= vector_fetch_in;
            inserted_is_jump_out <= vector_fetch_in && jump_mode_in[word_idx_q];
            if (vector_fetch_in) begin
                word_idx_q <= !word_idx_q;
            end
        end
    end
endmodule : fetch_pipeline_model

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [15:0] PRI_P = vic_pkg::PERIPH_PRIO_INDEX;
    localparam logic [15:0] PRI_C = vic_pkg::CORE_PRIO_INDEX;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic reset_instr = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [vic_pkg::ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = '0;
    logic [4:0] core_pulse = '0;
    logic [7:0] periph_req = '0;
    logic [4:0] pins_n = '1;
    logic [1:0] mask = '0;
    logic [15:0] vbase = '0;
    logic [1:0] jump_mode = '0;
    logic slots_on = 1'b0;
    logic fetch_slot, ins_word, ins_jump, freeze, vfetch, push, fast, ack;
    logic [15:0] vaddr;
    logic [31:0] rdat;
    logic [3:0] ext_ack;
    logic [3:0] ack_seen = '0;
    logic [15:0] addr_q [$];
    int push_cnt = 0;
    int fast_cnt = 0;
    int miscompares = 0;
    int cmp_count = 0;

    vectored_interrupt_controller i_vectored_interrupt_controller (
        .clk_in(clk_in), .reset_in(reset_in), .reset_instr_in(reset_instr),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .stack_error_in(core_pulse[0]), .illegal_opcode_exception_in(core_pulse[1]),
        .debug_request_in(core_pulse[2]), .trap_in(core_pulse[3]), .periph_nmi_in(core_pulse[4]),
        .periph_req_in(periph_req), .nmi_n_in(pins_n[0]), .ext_request_a_n_in(pins_n[1]),
        .ext_request_b_n_in(pins_n[2]), .ext_request_c_n_in(pins_n[3]), .ext_request_d_n_in(pins_n[4]),
        .mask_high_bit_in(mask[1]), .mask_low_bit_in(mask[0]), .vector_base_in(vbase),
        .fetch_slot_in(fetch_slot), .inserted_word_in(ins_word), .inserted_is_jump_in(ins_jump),
        .freeze_pc_out(freeze), .vector_fetch_out(vfetch), .vector_addr_out(vaddr),
        .ext_ack_out(ext_ack), .push_context_out(push), .fast_done_out(fast)
    );

    fetch_pipeline_model i_fetch_pipeline_model (
        .clk_in(clk_in), .reset_in(reset_in), .enable_in(slots_on), .jump_mode_in(jump_mode),
        .vector_fetch_in(vfetch), .fetch_slot_out(fetch_slot), .inserted_word_out(ins_word),
        .inserted_is_jump_out(ins_jump)
    );

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // ====================
    // Monitor and helpers
    always @(posedge clk_in) begin
        if (vfetch === 1'b1) addr_q.push_back(vaddr);
        if (vfetch === 1'b1) check(freeze, 32'h1);
        if (push === 1'b1) push_cnt++;
        if (fast === 1'b1) fast_cnt++;
        if (ext_ack !== 4'h0) ack_seen = ack_seen | ext_ack;
    end

    function automatic bit permitted(input int code, input int m);
        return code != 0 && code - 1 >= m;
    endfunction : permitted

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic hang;
        miscompares++;
        $display("MISMATCH at %0t: wait bound hit, got %0h expected %0h", $time, 0, 1);
        final_report();
    endtask : hang

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [15:0] idx, input logic [15:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'h3;
        wb_dat <= {16'h0000, wd};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_in);
    endtask : wb_xfer

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] rd;
        wb_xfer(1'b1, idx, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, idx, 16'h0000, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic pulse(input logic [4:0] c, input logic [7:0] p);
        core_pulse <= c;
        periph_req <= p;
        @(posedge clk_in);
        core_pulse <= '0;
        periph_req <= '0;
        @(posedge clk_in);
    endtask : pulse

    task automatic serve(input int src);
        logic [15:0] exp;
        int n;
        exp = {vbase[15:8], vic_pkg::VEC_OFFSET[src]};
        n = 0;
        while (addr_q.size() < 2 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 200) hang();
        check(addr_q.pop_front(), exp);
        check(addr_q.pop_front(), exp | 16'h0001);
    endtask : serve

    task automatic none_for(input int k);
        repeat (k) @(posedge clk_in);
        check(addr_q.size(), 0);
    endtask : none_for

    // A masked request stays pending, so it is let through and discarded.
    task automatic drain;
        wr(PRI_P, 16'hFFFF);
        mask <= 2'h0;
        repeat (40) @(posedge clk_in);
        addr_q.delete();
    endtask : drain

    // ====================
    // Main sequence
    initial begin
        logic [15:0] r;
        int s, m, c, p, exp_push, exp_fast;
        exp_push = 0;
        exp_fast = 0;
        void'($urandom(73156));
        vbase <= 16'($urandom);
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        slots_on <= 1'b1;
        @(posedge clk_in);
        rd_chk(PRI_C, 32'h0);
        rd_chk(PRI_P, 32'h0);
        r = 16'($urandom);
        wr(PRI_P, r);
        rd_chk(PRI_P, {16'h0000, r});
        wr(PRI_C, 16'hFFFF);
        rd_chk(PRI_C, 32'h00000FFF);
        wr(16'h1234, 16'hFFFF);
        rd_chk(16'h1234, 32'h0);
        reset_instr <= 1'b1;
        @(posedge clk_in);
        reset_instr <= 1'b0;
        @(posedge clk_in);
        rd_chk(PRI_C, 32'h0);
        rd_chk(PRI_P, 32'h0);
        mask <= 2'h3;
        for (s = 0; s < 5; s++) begin
            jump_mode <= 2'($urandom);
            @(posedge clk_in);
            pulse(5'h01 << s, 8'h00);
            serve((s == 4) ? vic_pkg::SRC_NMI + 1 : s);
            repeat (4) @(posedge clk_in);
            if (jump_mode != 2'h0) exp_push++;
            else exp_fast++;
            check(push_cnt, exp_push);
            check(fast_cnt, exp_fast);
        end
        pulse(5'h1F, 8'h00);
        for (s = 0; s < 6; s++) if (s != 4) serve(s);
        pins_n[0] <= 1'b0;
        serve(vic_pkg::SRC_NMI);
        none_for(30);
        pins_n[0] <= 1'b1;
        for (m = 0; m < 4; m++) begin
            for (c = 0; c < 4; c++) begin
                p = $urandom_range(7);
                wr(PRI_P, 16'(c) << (2 * p));
                mask <= 2'(m);
                pulse(5'h00, 8'h01 << p);
                if (permitted(c, m)) serve(vic_pkg::SRC_PER + p);
                else none_for(20);
                drain();
            end
        end
        wr(PRI_C, 16'h0007);
        ack_seen = '0;
        pins_n[1] <= 1'b0;
        serve(vic_pkg::SRC_EXT);
        none_for(30);
        check(ack_seen, 4'h1);
        pins_n[1] <= 1'b1;
        wr(PRI_C, 16'h0018);
        pins_n[2] <= 1'b0;
        serve(vic_pkg::SRC_EXT + 1);
        serve(vic_pkg::SRC_EXT + 1);
        pins_n[2] <= 1'b1;
        repeat (30) @(posedge clk_in);
        addr_q.delete();
        wr(PRI_C, 16'h0000);
        pins_n[3] <= 1'b0;
        none_for(30);
        wr(PRI_C, 16'h01C0);
        none_for(30);
        pins_n[3] <= 1'b1;
        slots_on <= 1'b0;
        wr(PRI_C, 16'h0600);
        pins_n[4] <= 1'b0;
        repeat (6) @(posedge clk_in);
        wr(PRI_C, 16'h0000);
        pins_n[4] <= 1'b1;
        slots_on <= 1'b1;
        none_for(30);
        slots_on <= 1'b0;
        wr(PRI_C, 16'h0DB6);
        wr(PRI_P, 16'h0002);
        pins_n[4:1] <= 4'h0;
        pulse(5'h00, 8'h01);
        repeat (6) @(posedge clk_in);
        slots_on <= 1'b1;
        for (s = 0; s < 5; s++) serve(vic_pkg::SRC_EXT + s);
        pins_n <= '1;
        slots_on <= 1'b0;
        wr(PRI_C, 16'h0005);
        wr(PRI_P, 16'h0003);
        pins_n[1] <= 1'b0;
        pulse(5'h00, 8'h01);
        repeat (6) @(posedge clk_in);
        slots_on <= 1'b1;
        serve(vic_pkg::SRC_PER);
        serve(vic_pkg::SRC_EXT);
        none_for(30);
        final_report();
    end
endmodule : tb

`default_nettype wire
